// File: core/lintc_pkg.sv
package lintc_pkg;
   localparam int CLK_HZ          = 25000000;
   // Fault pin settles about 25 us after a falling transmit edge
   localparam int FAULT_VALID_US  = 25;
   localparam int FAULT_VALID_CYC = (FAULT_VALID_US * (CLK_HZ / 1000000));
   // Transmit-dominant timeout of about 10 ms
   localparam int TXD_TO_MS       = 10;
   localparam int TXD_TO_CYC      = TXD_TO_MS * (CLK_HZ / 1000);
   // Bus-dominant timeout of about 25 ms
   localparam int BUS_TO_MS       = 25;
   localparam int BUS_TO_CYC      = BUS_TO_MS * (CLK_HZ / 1000);
   // Time the select pin is held low to send the device to power-down
   localparam int SLEEP_US        = 10;
   localparam int SLEEP_CYC       = SLEEP_US * (CLK_HZ / 1000000);
   localparam int BYTE_W          = 8;
   localparam int FIFO_DEPTH      = 8;
   localparam logic [1:0] BAUD_RST = 2'h0;

   typedef enum logic [4:0] {
      LINTC_ST_IDLE   = 5'h01,
      LINTC_ST_SHIFT  = 5'h02,
      LINTC_ST_CHECK  = 5'h04,
      LINTC_ST_TXOFF  = 5'h08,
      LINTC_ST_SLEEP  = 5'h10
   } lintc_state_t;
endpackage : lintc_pkg

// File: core/lintc_fifo_if.sv
`timescale 1ns/1ps
interface lintc_fifo_if #(parameter int WIDTH = 8);
   logic             in_valid;
   logic             in_ready;
   logic [WIDTH-1:0] in_data;
   logic             out_valid;
   logic             out_ready;
   logic [WIDTH-1:0] out_data;
   modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
   modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface : lintc_fifo_if

// File: core/lintc_fifo.sv
`timescale 1ns/1ps
module lintc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst_n,
   // Streams
   lintc_fifo_if.fifo f
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   assign f.in_ready  = (count != (AW+1)'(DEPTH));
   assign f.out_valid = (count != '0);
   assign f.out_data  = mem[rd_ptr];
   assign push        = f.in_valid && f.in_ready;
   assign pop         = f.out_valid && f.out_ready;

   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_ptr] <= f.in_data;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   a_fifo_no_over: assert property (@(posedge clock) disable iff (!rst_n)
      count <= (AW+1)'(DEPTH))
      else $error("fifo count above depth");
endmodule : lintc_fifo

// File: core/lintc_ctrl.sv
`timescale 1ns/1ps
module lintc_ctrl
   import lintc_pkg::*;
#(
   parameter int TXD_TO     = TXD_TO_CYC,
   parameter int BUS_TO     = BUS_TO_CYC,
   parameter int BIT_DIV    = 1250,
   parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              rst_n,
   // User commands
   input  wire logic              enable,
   input  wire logic              sleep,
   input  wire logic              local_wake_arm,
   input  wire logic              wake_pulse,
   input  wire logic              txoff_cmd,
   input  wire logic              tx_valid,
   output      logic              tx_ready,
   input  wire logic [lintc_pkg::BYTE_W-1:0] tx_data,
   output      logic              rx_valid,
   output      logic [lintc_pkg::BYTE_W-1:0] rx_data,
   // Status
   output      logic              fault_seen,
   output      logic              thermal_or_short,
   output      logic              bus_timeout,
   output      logic              regulator_on,
   output      logic              busy,
   // Device pins
   output      logic              select_o,
   output      logic              select_oe,
   output      logic              txd,
   output      logic              wake_n,
   input  wire logic              rxd,
   input  wire logic              fault_txen_pin_i,
   output      logic              fault_txen_pin_o,
   output      logic              fault_txen_pin_oe,
   input  wire logic              vren
);
   import lintc_pkg::*;

   lintc_state_t        state;
   lintc_state_t        next_state;
   logic [15:0]         div_cnt;
   logic                bit_tick;
   logic [3:0]          bit_idx;
   logic [9:0]          shreg;
   logic [31:0]         txd_low_cnt;
   logic [31:0]         bus_dom_cnt;
   logic [31:0]         fv_cnt;
   logic                txd_q;
   logic                rx_q;
   logic [3:0]          rx_bit;
   logic [15:0]         rx_div;
   logic [7:0]          rx_sh;
   logic                rx_busy;

   lintc_fifo_if #(.WIDTH(BYTE_W)) fq ();

   lintc_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH_P)) u_fifo (
      .clock (clock),
      .rst_n (rst_n),
      .f     (fq.fifo)
   );

   assign fq.in_valid = tx_valid;
   assign fq.in_data  = tx_data;
   assign tx_ready    = fq.in_ready;
   assign fq.out_ready = (state == LINTC_ST_IDLE) && enable && !txoff_cmd;

   // One free-running timebase produces the bit enable
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= (div_cnt == 16'(BIT_DIV - 1)) ? 16'h0000 : div_cnt + 16'h0001;
      end
   end
   assign bit_tick = (div_cnt == 16'h0000);

   always_comb begin
      next_state = state;
      unique case (state)
         LINTC_ST_IDLE: begin
            if (sleep) begin
               next_state = LINTC_ST_SLEEP;
            end else if (fq.out_valid && fq.out_ready) begin
               next_state = LINTC_ST_SHIFT;
            end
         end
         LINTC_ST_SHIFT: begin
            if (bit_tick && bit_idx == 4'hA) begin
               next_state = LINTC_ST_IDLE;
            end else if (txd_low_cnt >= 32'(TXD_TO - 2)) begin
               next_state = LINTC_ST_TXOFF;
            end
         end
         LINTC_ST_CHECK: next_state = LINTC_ST_IDLE;
         LINTC_ST_TXOFF: begin
            if (bit_tick) begin
               next_state = LINTC_ST_IDLE;
            end
         end
         LINTC_ST_SLEEP: begin
            if (!sleep && (enable || wake_pulse)) begin
               next_state = LINTC_ST_IDLE;
            end
         end
         default: next_state = LINTC_ST_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state <= LINTC_ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Serial shifter: start bit, 8 data bits LSB first, stop bit
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         shreg   <= 10'h3FF;
         bit_idx <= 4'h0;
      end else if (state == LINTC_ST_IDLE && fq.out_valid && fq.out_ready) begin
         shreg   <= {1'b1, fq.out_data, 1'b0};
         bit_idx <= 4'h0;
      end else if (state == LINTC_ST_SHIFT && bit_tick) begin
         shreg   <= {1'b1, shreg[9:1]};
         bit_idx <= bit_idx + 4'h1;
      end
   end

   // Transmit idles high and a timed-out dominant is released
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         txd <= 1'b1;
      end else if (state == LINTC_ST_SHIFT && next_state == LINTC_ST_SHIFT && bit_tick) begin
         txd <= shreg[0];
      end else if (state != LINTC_ST_SHIFT || next_state != LINTC_ST_SHIFT) begin
         txd <= 1'b1;
      end
   end

   // Guard against holding transmit low too long
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         txd_low_cnt <= '0;
      end else if (txd) begin
         txd_low_cnt <= '0;
      end else begin
         txd_low_cnt <= txd_low_cnt + 32'd1;
      end
   end

   // Mirror of the device bus-dominant timer, reset on recessive
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         bus_dom_cnt <= '0;
         bus_timeout <= 1'b0;
      end else if (rxd) begin
         bus_dom_cnt <= '0;
         bus_timeout <= 1'b0;
      end else if (bus_dom_cnt >= 32'(BUS_TO - 1)) begin
         bus_timeout <= 1'b1;
      end else begin
         bus_dom_cnt <= bus_dom_cnt + 32'd1;
      end
   end

   // Fault valid window after each falling transmit edge
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         txd_q  <= 1'b1;
         fv_cnt <= '0;
      end else begin
         txd_q <= txd;
         if (txd_q && !txd) begin
            fv_cnt <= 32'(FAULT_VALID_CYC);
         end else if (fv_cnt != '0) begin
            fv_cnt <= fv_cnt - 32'd1;
         end
      end
   end

   // Fault low counts only when not self-driven
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         fault_seen       <= 1'b0;
         thermal_or_short <= 1'b0;
      end else begin
         // The edge itself is masked too, before the window counter is loaded
         fault_seen <= !fault_txen_pin_i && !fault_txen_pin_oe && fv_cnt == '0
                       && !(txd_q && !txd);
         thermal_or_short <= !fault_txen_pin_i && !fault_txen_pin_oe && fv_cnt == '0
                             && !(txd_q && !txd) && !txd && rxd;
      end
   end

   // Select low after reset, floated for local wake
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         select_o  <= 1'b0;
         select_oe <= 1'b1;
      end else begin
         select_o  <= enable && !sleep && state != LINTC_ST_SLEEP;
         select_oe <= !(local_wake_arm && state == LINTC_ST_SLEEP);
      end
   end

   // Wake pin pulse for the wake variant
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wake_n <= 1'b1;
      end else begin
         wake_n <= !(wake_pulse && state == LINTC_ST_SLEEP);
      end
   end

   // Open-drain transmit disable command
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         fault_txen_pin_oe <= 1'b0;
         regulator_on      <= 1'b0;
      end else begin
         fault_txen_pin_oe <= txoff_cmd;
         regulator_on      <= vren;
      end
   end
   assign fault_txen_pin_o = 1'b0;
   assign busy = (state != LINTC_ST_IDLE) || fq.out_valid;

   // Receiver samples the device receive output
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rx_q     <= 1'b1;
         rx_busy  <= 1'b0;
         rx_bit   <= 4'h0;
         rx_div   <= '0;
         rx_sh    <= 8'h00;
         rx_valid <= 1'b0;
         rx_data  <= 8'h00;
      end else begin
         rx_q     <= rxd;
         rx_valid <= 1'b0;
         if (!rx_busy) begin
            if (rx_q && !rxd) begin
               rx_busy <= 1'b1;
               rx_bit  <= 4'h0;
               rx_div  <= 16'(BIT_DIV / 2);
            end
         end else if (rx_div == 16'h0000) begin
            rx_div <= 16'(BIT_DIV - 1);
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == 4'h0 && rxd) begin
               rx_busy <= 1'b0;
            end else if (rx_bit >= 4'h1 && rx_bit <= 4'h8) begin
               rx_sh <= {rxd, rx_sh[7:1]};
            end else if (rx_bit == 4'h9) begin
               rx_busy  <= 1'b0;
               rx_valid <= rxd;
               rx_data  <= rx_sh;
            end
         end else begin
            rx_div <= rx_div - 16'h0001;
         end
      end
   end

   a_txd_bounded: assert property (@(posedge clock) disable iff (!rst_n)
      txd_low_cnt < 32'(TXD_TO))
      else $error("transmit held low past timeout");
   a_select_sleep: assert property (@(posedge clock) disable iff (!rst_n)
      state == LINTC_ST_SLEEP |=> !select_o)
      else $error("select high in sleep");
   a_txd_idle_high: assert property (@(posedge clock) disable iff (!rst_n)
      (state == LINTC_ST_IDLE && $past(state) == LINTC_ST_IDLE) |-> txd)
      else $error("transmit not idle high");
   a_fault_masked: assert property (@(posedge clock) disable iff (!rst_n)
      (txd_q && !txd) |=> !fault_seen)
      else $error("fault sampled inside mask");
   a_own_low: assert property (@(posedge clock) disable iff (!rst_n)
      $past(fault_txen_pin_oe) |-> !fault_seen)
      else $error("own command seen as fault");
   a_txen_cmd: assert property (@(posedge clock) disable iff (!rst_n)
      txoff_cmd |=> fault_txen_pin_oe)
      else $error("transmit disable not driven");
   a_bus_tmo: assert property (@(posedge clock) disable iff (!rst_n)
      rxd |=> !bus_timeout)
      else $error("bus timeout not cleared");
   a_reg_follow: assert property (@(posedge clock) disable iff (!rst_n)
      vren |=> regulator_on)
      else $error("regulator status stale");
endmodule : lintc_ctrl

// File: tb/lintc_dev_model.sv
`timescale 1ns/1ps
module lintc_dev_model #(
   parameter int TXD_TO = 200,
   parameter int BUS_TO = 500,
   parameter int DEB    = 4
) (
   // Clock and power-on
   input  wire logic clock,
   input  wire logic por_n,
   // Controller pins
   input  wire logic select,
   input  wire logic txd,
   input  wire logic wake_n,
   input  wire logic fault_pin,
   output      logic rxd,
   output      logic fault_low,
   output      logic vren,
   // Bus and die conditions
   input  wire logic ext_dom,
   input  wire logic thermal,
   input  wire logic short_vbb
);
   typedef enum logic [1:0] {LINTC_PD, LINTC_RDY, LINTC_OP, LINTC_TRANSMITTER_OFF_MODE} lintc_mode_t;
   lintc_mode_t mode;
   logic        sel_q, txd_q, wake_q, txto, busto, tx_on, bus;
   int          txd_cnt, bus_cnt, act_cnt;
   assign tx_on = mode == LINTC_OP && fault_pin && !txto && !busto && !thermal;
   // A bus shorted to battery stays recessive whatever is driven
   assign bus = short_vbb || !(ext_dom || (tx_on && !txd));
   assign rxd = bus;
   // The controller's own fault-pin low is never echoed; its transmit low is, while the bus is shorted to battery
   assign fault_low = thermal || busto || (short_vbb && !txd);
   assign vren = mode != LINTC_PD;
   always_ff @(posedge clock) begin
      sel_q <= select;
      txd_q <= txd;
      wake_q <= wake_n;
   end
   always_ff @(posedge clock) begin
      if (!por_n) begin
         mode <= select ? LINTC_OP : LINTC_RDY;
      end else begin
         case (mode)
            LINTC_RDY: begin
               if (select && !sel_q) mode <= txd ? LINTC_OP : LINTC_TRANSMITTER_OFF_MODE;
            end
            LINTC_PD: begin
               if ((wake_q && !wake_n) || select || act_cnt >= DEB)
                  mode <= select ? LINTC_OP : LINTC_RDY;
            end
            default: begin
               if (sel_q && !select) mode <= LINTC_PD;
               else if (!fault_pin || txto || busto || thermal) mode <= LINTC_TRANSMITTER_OFF_MODE;
               else if (txd) mode <= LINTC_OP;
            end
         endcase
      end
   end
   always_ff @(posedge clock) begin
      if (!por_n || txd) txd_cnt <= 0;
      else if (txd_cnt < TXD_TO) txd_cnt <= txd_cnt + 1;
   end
   always_ff @(posedge clock) begin
      if (!por_n || (txd && !txd_q)) txto <= 1'b0;
      else if (txd_cnt >= TXD_TO) txto <= 1'b1;
   end
   always_ff @(posedge clock) begin
      if (!por_n || bus) bus_cnt <= 0;
      else if (bus_cnt < BUS_TO) bus_cnt <= bus_cnt + 1;
   end
   always_ff @(posedge clock) begin
      if (!por_n || (bus && select)) busto <= 1'b0;
      else if (bus_cnt >= BUS_TO) busto <= 1'b1;
   end
   always_ff @(posedge clock) begin
      if (!por_n || bus || mode != LINTC_PD) act_cnt <= 0;
      else if (act_cnt < DEB) act_cnt <= act_cnt + 1;
   end
endmodule : lintc_dev_model

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   import lintc_pkg::*;
   localparam int TXD_TO = 200;
   localparam int BUS_TO = 500;
   localparam int LIMIT  = 20000;
   logic              clock = 1'b0;
   logic              rst_n, enable, sleep, arm, wake_pulse, txoff_cmd, tx_valid;
   logic [BYTE_W-1:0] tx_data, rx_data;
   logic              tx_ready, rx_valid, fault_seen, thermal_or_short, bus_timeout;
   logic              regulator_on, busy, select_o, select_oe, txd, wake_n, rxd;
   logic              fault_o, fault_oe, vren, fault_low, ext_dom, thermal, wake_src;
   logic              ignore_rx, short_vbb;
   logic [BYTE_W-1:0] exp_q[$];
   int                err_count, checks_done, cycles;
   logic [31:0]       seed = 32'h0000B323;
   // Select has a pull-down; the fault pin is open drain with a pull-up
   wire               select = select_oe ? select_o : wake_src;
   wire               fault_wire = !(fault_low || (fault_oe && !fault_o));
   lintc_ctrl #(.TXD_TO(TXD_TO), .BUS_TO(BUS_TO), .BIT_DIV(8)) u_lintc_ctrl (
      .clock(clock), .rst_n(rst_n), .enable(enable), .sleep(sleep),
      .local_wake_arm(arm), .wake_pulse(wake_pulse), .txoff_cmd(txoff_cmd),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
      .rx_data(rx_data), .fault_seen(fault_seen), .thermal_or_short(thermal_or_short),
      .bus_timeout(bus_timeout), .regulator_on(regulator_on), .busy(busy),
      .select_o(select_o), .select_oe(select_oe), .txd(txd), .wake_n(wake_n), .rxd(rxd),
      .fault_txen_pin_i(fault_wire), .fault_txen_pin_o(fault_o),
      .fault_txen_pin_oe(fault_oe), .vren(vren));
   lintc_dev_model #(.TXD_TO(TXD_TO), .BUS_TO(BUS_TO)) u_lintc_dev_model (
      .clock(clock), .por_n(rst_n), .select(select), .txd(txd), .wake_n(wake_n),
      .fault_pin(fault_wire), .rxd(rxd), .fault_low(fault_low), .vren(vren),
      .ext_dom(ext_dom), .thermal(thermal), .short_vbb(short_vbb));
   always #20 clock = ~clock;
   function automatic logic [31:0] xorshift();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xorshift
   function automatic logic probe(input int k);
      case (k)
         0: return regulator_on;
         1: return fault_seen;
         2: return bus_timeout;
         3: return select_oe;
         default: return exp_q.size() == 0;
      endcase
   endfunction : probe
   task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
      checks_done++;
      if (seen !== want) begin
         err_count++;
         $display("CHECK FAILED at %0t: %s seen %h want %h", $time, what, seen, want);
      end
   endtask : check
   task automatic await(input int k, input logic v, input int lim, input string what);
      int n;
      n = 0;
      while (probe(k) !== v && n < lim) begin
         @(negedge clock);
         n++;
      end
      check({7'h00, probe(k)}, {7'h00, v}, what);
   endtask : await
   task automatic push(input logic [7:0] d);
      tx_data = d;
      tx_valid = 1'b1;
      while (tx_ready !== 1'b1) @(negedge clock);
      exp_q.push_back(d);
      @(negedge clock);
   endtask : push
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask : done
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_sim
   // Each looped-back byte is matched against the oldest one sent
   always @(negedge clock) begin
      if (rst_n && !ignore_rx && rx_valid === 1'b1) begin
         if (exp_q.size() == 0) check(8'h01, 8'h00, "stray byte");
         else check(rx_data, exp_q.pop_front(), "looped byte");
      end
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == LIMIT) begin
         err_count++;
         end_sim();
      end
   end
   initial begin
      {rst_n, enable, sleep, arm, wake_pulse, txoff_cmd, tx_valid} = 7'h00;
      {ext_dom, thermal, wake_src, ignore_rx, short_vbb} = 5'h00;
      tx_data = 8'h00;
      err_count = 0;
      checks_done = 0;
      cycles = 0;
      repeat (20) @(negedge clock);
      rst_n = 1'b1;
      check({3'h0, select_o, select_oe, txd, wake_n, fault_oe}, 8'h0E, "idle pins");
      await(0, 1'b1, 10, "regulator on");
      done("reset");
      for (int i = 0; i < FIFO_DEPTH; i++) push(8'(xorshift()));
      check({7'h00, tx_ready}, 8'h00, "fifo full");
      check(8'(exp_q.size()), 8'h08, "held in ready");
      enable = 1'b1;
      push(8'(xorshift()));
      tx_valid = 1'b0;
      await(4, 1'b1, 2000, "bytes looped");
      done("loopback");
      txoff_cmd = 1'b1;
      push(8'(xorshift()));
      tx_valid = 1'b0;
      repeat (200) @(negedge clock);
      check(8'(exp_q.size()), 8'h01, "held by txoff");
      check({fault_wire, fault_seen, txd, 5'h00}, 8'h20, "own low");
      txoff_cmd = 1'b0;
      await(4, 1'b1, 300, "sent after txoff");
      done("txoff");
      short_vbb = 1'b1;
      tx_data = 8'h00;
      tx_valid = 1'b1;
      @(negedge clock);
      tx_valid = 1'b0;
      repeat (40) @(negedge clock);
      check({7'h00, fault_wire}, 8'h00, "short on pin");
      check({7'h00, fault_seen}, 8'h00, "fault masked");
      repeat (100) @(negedge clock);
      check({7'h00, fault_seen}, 8'h00, "no late fault");
      short_vbb = 1'b0;
      repeat (20) @(negedge clock);
      done("short");
      thermal = 1'b1;
      await(1, 1'b1, 1000, "thermal fault");
      check({7'h00, thermal_or_short}, 8'h00, "no short");
      thermal = 1'b0;
      await(1, 1'b0, 20, "fault cleared");
      done("thermal");
      ignore_rx = 1'b1;
      ext_dom = 1'b1;
      await(2, 1'b1, BUS_TO + 20, "bus timeout");
      await(1, 1'b1, 20, "timeout on pin");
      ext_dom = 1'b0;
      await(2, 1'b0, 20, "bus recovered");
      await(1, 1'b0, 20, "pin released");
      repeat (150) @(negedge clock);
      ignore_rx = 1'b0;
      done("bus dominant");
      sleep = 1'b1;
      enable = 1'b0;
      await(0, 1'b0, 20, "regulator off");
      wake_pulse = 1'b1;
      await(0, 1'b1, 20, "wake edge");
      wake_pulse = 1'b0;
      sleep = 1'b0;
      enable = 1'b1;
      repeat (10) @(negedge clock);
      enable = 1'b0;
      sleep = 1'b1;
      arm = 1'b1;
      await(0, 1'b0, 20, "asleep again");
      await(3, 1'b0, 20, "select floated");
      wake_src = 1'b1;
      await(0, 1'b1, 20, "local wake");
      done("sleep");
      end_sim();
   end
endmodule : testbench
